//--- dv/bsl_far_model.sv
// Far-side model: byte source with stalls and a RAM that keeps its writes
`timescale 1ns/1ps
`default_nettype none
module bsl_far_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  output logic [7:0]       src_byte,
  output logic             src_valid,
  input  wire logic        src_ready,
  input  wire logic        ram_we,
  input  wire logic [31:0] ram_addr,
  input  wire logic [31:0] ram_wdata,
  output logic             ram_ready
);
  logic [7:0]  img [64];   // Image bytes, filled by the bench
  logic [31:0] mem [16];   // Words written, indexed by word address
  int          n;          // Image length in bytes
  int          idx;        // Next byte to present
  int          wr;         // Count of accepted RAM writes
  int          tick;       // Free cycle count for stall patterns
  logic        slow;       // Stall both source and RAM
  logic        hs;         // Byte taken at the last rising edge
  initial begin
    src_byte = 8'h00;
    src_valid = 1'b0;
    ram_ready = 1'b1;
    slow = 1'b0;
    n = 0;
    tick = 0;
    hs = 1'b0;
  end
  // Handshakes and writes are judged at the sampling edge
  always @(posedge clk) begin
    hs = src_valid & src_ready;
    if (!reset_n) begin
      wr = 0;
      foreach (mem[i]) mem[i] = 32'h0000_0000;
    end else if (ram_we && ram_ready) begin
      mem[ram_addr[5:2]] = ram_wdata;
      wr++;
    end
  end
  // Drive just after the edge; a byte holds until taken
  always @(negedge clk) begin
    tick++;
    // Slow RAM drains slower than the source fills, so the buffer backs up
    ram_ready = !slow || tick[3:0] == 4'h0;
    if (!reset_n) begin
      idx = 0;
      src_valid = 1'b0;
    end else begin
      if (hs) idx++;
      if (hs || !src_valid) begin
        src_valid = idx < n && !(slow && tick[0]);
        // Whole bytes, bit order already fixed by the source
        src_byte = src_valid ? img[idx] : ~src_byte;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/bsl_loader_props.sv
// Concurrent checks on the loader ports, bound to every loader instance
`timescale 1ns/1ps
`default_nettype none
module bsl_loader_props #(
  parameter int unsigned GPIO_COUNT = 8
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic [31:0]           security_word,
  input wire logic                  src_valid,
  input wire logic                  src_ready,
  input wire logic [31:0]           otp_addr,
  input wire logic [31:0]           ram_addr,
  input wire logic [31:0]           ram_wdata,
  input wire logic                  ram_we,
  input wire logic                  ram_ready,
  input wire logic [GPIO_COUNT-1:0] gpio_pull_down,
  input wire logic [2:0]            boot_source,
  input wire logic                  first_interchip_link,
  input wire logic                  link_two_wire,
  input wire logic                  run_start,
  input wire logic [31:0]           run_addr,
  input wire logic                  boot_fail
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_pull_hold;
    $rose(reset_n) |-> &gpio_pull_down;
  endproperty
  a_pull_hold: assert property (p_pull_hold)
    else $error("pulls off early");
  property p_phase_quiet;
    $rose(reset_n) |-> !src_ready [*4];
  endproperty
  a_phase_quiet: assert property (p_phase_quiet)
    else $error("ready in phase");
  property p_secure;
    security_word[5] && boot_source != 3'h0 |->
      boot_source == bsl_pkg::SRC_OTP && !first_interchip_link;
  endproperty
  a_secure: assert property (p_secure)
    else $error("secure boot ignored");
  property p_link_only;
    first_interchip_link |->
      boot_source == bsl_pkg::SRC_CHAN_END && link_two_wire;
  endproperty
  a_link_only: assert property (p_link_only)
    else $error("link misuse");
  property p_src_stable;
    boot_source != 3'h0 |=> $stable(boot_source);
  endproperty
  a_src_stable: assert property (p_src_stable)
    else $error("source moved");
  property p_fail_excl;
    boot_fail |-> !run_start;
  endproperty
  a_fail_excl: assert property (p_fail_excl)
    else $error("failed yet run");
  // Once the image is over no further byte may be accepted
  property p_quiet_end;
    run_start || boot_fail |-> !src_ready;
  endproperty
  a_quiet_end: assert property (p_quiet_end)
    else $error("ready after end");
  property p_run_hold;
    run_start |=> run_start && run_addr == bsl_pkg::RAM_BASE;
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("run not at zero");
  property p_ram_hold;
    ram_we && !ram_ready |=> ram_we && $stable(ram_addr) && $stable(ram_wdata);
  endproperty
  a_ram_hold: assert property (p_ram_hold)
    else $error("write dropped");
  property p_otp_step;
    boot_source == bsl_pkg::SRC_OTP && src_valid && src_ready |=>
      otp_addr == $past(otp_addr) + 32'h0000_0001;
  endproperty
  a_otp_step: assert property (p_otp_step)
    else $error("otp address step");
  c_run: cover property ($rose(run_start));
  c_fail: cover property ($rose(boot_fail));
  c_stall: cover property (ram_we && !ram_ready);
  c_otp: cover property (boot_source == bsl_pkg::SRC_OTP && src_ready);
endmodule
bind bsl_loader bsl_loader_props #(.GPIO_COUNT(GPIO_COUNT)) u_props (.clk,
  .reset_n, .security_word, .src_valid, .src_ready, .otp_addr, .ram_addr,
  .ram_wdata, .ram_we, .ram_ready, .gpio_pull_down, .boot_source,
  .first_interchip_link, .link_two_wire, .run_start, .run_addr, .boot_fail);
`default_nettype wire

//--- dv/tb_bsl_loader.sv
// Self-checking bench for the boot source and image loader
`timescale 1ns/1ps
`default_nettype none
module tb_bsl_loader;
  localparam int unsigned PH = 4;  // Short reset phase keeps runs brief
  logic clk, reset_n, src_valid, src_ready, ram_we, ram_ready, boot_busy;
  logic first_interchip_link, link_two_wire, run_start, boot_fail;
  logic [2:0]  strap, boot_source, src_t1;
  logic [7:0]  src_byte, gpio_pull_down;
  logic [31:0] security_word, otp_addr, ram_addr, ram_wdata, run_addr;
  int          miscompares, comparisons;
  // Straps, secure bit, tile 0 source, tile 1 source, link enable
  logic [10:0] rows [7] = '{{3'h0,1'b0,3'h1,3'h4,1'b0},
    {3'h1,1'b0,3'h2,3'h4,1'b0}, {3'h2,1'b0,3'h3,3'h4,1'b0},
    {3'h3,1'b0,3'h3,3'h3,1'b0}, {3'h4,1'b0,3'h4,3'h4,1'b1},
    {3'h0,1'b1,3'h5,3'h5,1'b0}, {3'h4,1'b1,3'h5,3'h5,1'b0}};
  bsl_loader #(.TILE_INDEX(0), .PHASE_CYCLES(PH)) uut (.clk, .reset_n,
    .boot_strap_bit0(strap[0]), .boot_strap_bit1(strap[1]),
    .boot_strap_bit2(strap[2]), .security_word, .src_byte, .src_valid,
    .src_ready, .otp_addr, .ram_addr, .ram_wdata, .ram_we, .ram_ready,
    .gpio_pull_down, .boot_source, .first_interchip_link, .link_two_wire,
    .boot_busy, .run_start, .run_addr, .boot_fail);
  // Second tile only shows its source choice
  bsl_loader #(.TILE_INDEX(1), .PHASE_CYCLES(PH)) uut_t1 (.clk, .reset_n,
    .boot_strap_bit0(strap[0]), .boot_strap_bit1(strap[1]),
    .boot_strap_bit2(strap[2]), .security_word, .src_byte(8'h00),
    .src_valid(1'b0), .src_ready(), .otp_addr(), .ram_addr(), .ram_wdata(),
    .ram_we(), .ram_ready(1'b1), .gpio_pull_down(), .boot_source(src_t1),
    .first_interchip_link(), .link_two_wire(), .boot_busy(), .run_start(),
    .run_addr(), .boot_fail());
  bsl_far_model far (.clk, .reset_n, .src_byte, .src_valid, .src_ready,
    .ram_we, .ram_addr, .ram_wdata, .ram_ready);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Program word k of every test image
  function automatic logic [31:0] word(input int k);
    return 32'h0A0B_0C0D + k * 32'h0101_0101;
  endfunction
  // One byte into the reflected CRC register
  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0]  b);
    c = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ bsl_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction
  // Build an image; kind 0 good check, 1 skip value, 2 wrong check
  task automatic load(input int s, input int kind, input logic sl);
    logic [31:0] c, w;
    int          n;
    c = bsl_pkg::CRC_PRESET;
    n = 0;
    for (int k = -1; k <= s; k++) begin
      w = k < 0 ? 32'(s) : word(k);
      if (k == s) w = kind == 1 ? 32'h0D15_AB1E : kind == 2 ? c : ~c;
      for (int j = 0; j < 4; j++) begin
        far.img[n] = w[8*j +: 8];  // Least byte first
        if (k < s) c = crc8(c, w[8*j +: 8]);
        n++;
      end
    end
    far.n = n;
    far.slow = sl;
  endtask
  task automatic do_reset(input logic [2:0] st, input logic [31:0] sw);
    reset_n = 1'b0;
    strap = st;
    security_word = sw;
    repeat (6) @(negedge clk);
    check(gpio_pull_down, 8'hFF);
    check(boot_busy, 1'b0);
    reset_n = 1'b1;
  endtask
  // Full boot, bounded wait for the verdict, then RAM contents
  task automatic boot(input logic [2:0] st, input logic [31:0] sw, input int s,
                      input int kind, input logic sl, input logic ok);
    load(s, kind, sl);
    do_reset(st, sw);
    for (int t = 0; t < 3000 && run_start !== 1'b1 && boot_fail !== 1'b1; t++)
      @(negedge clk);
    if (run_start !== 1'b1 && boot_fail !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    check(run_start, ok);
    check(boot_fail, !ok);
    check(run_addr, 32'h0000_0000);
    check(boot_busy, 1'b0);
    if (ok) check(far.wr, s);
    for (int k = 0; k < s && ok; k++)
      check(far.mem[k], word(k));
  endtask
  initial begin
    logic [2:0] st, e0, e1;
    logic       se, el;
    reset_n = 1'b0;
    strap = 3'h0;
    security_word = 32'h0000_0000;
    miscompares = 0;
    comparisons = 0;
    for (int r = 0; r < 7; r++) begin
      {st, se, e0, e1, el} = rows[r];
      far.n = 0;
      do_reset(st, {26'h000_0000, se, 5'h00});
      repeat (PH + 6) @(negedge clk);
      check(boot_source, e0);
      check(src_t1, e1);
      check({first_interchip_link, link_two_wire}, {el, el});
      check(gpio_pull_down, 8'h00);
      check(boot_busy, 1'b1);
      strap = ~st;
      repeat (4) @(negedge clk);
      check(boot_source, e0);
    end
    boot(3'h0, 32'h0000_0000, 3, 0, 1'b0, 1'b1);
    boot(3'h1, 32'h0000_0000, 5, 0, 1'b1, 1'b1);
    boot(3'h2, 32'h0000_0000, 2, 1, 1'b0, 1'b1);
    boot(3'h4, 32'h0000_0000, 0, 0, 1'b0, 1'b1);
    boot(3'h0, 32'h0000_0000, 2, 2, 1'b1, 1'b0);
    boot(3'h5, 32'h0000_0000, 1, 0, 1'b0, 1'b0);
    boot(3'h3, 32'h0000_0020, 1, 0, 1'b0, 1'b1);
    check(otp_addr, 32'h0000_000C);
    tally_and_finish();
  end
  // Whole-run guard against a hang
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- logic/bsl_loader.sv
// Boot source selection and length-prefixed image loader for one tile
// What this block does
// - Pull-downs enabled on all GPIO during reset
// - Internal reset phase runs before booting begins
// - Secure-boot bit forces OTP boot, ignores straps
// - Tile 0 source decoded from three straps
// - Tile 1 SPI target on 011, channel on other codes up to 100, none above
// - Only strap 100 enables link zero, two-wire
// - Image: word count, program words, check word
// - Check value 0D15AB1E skips CRC verification
// - Count and check value least byte first
// - Load at lowest RAM address, start there
// - CRC covers count bytes and program bytes
// - Reflected CRC-32, preset ones, final invert
// - Secure boot reads OTP from address zero
`timescale 1ns/1ps
`default_nettype none

module bsl_loader #(
  parameter int unsigned TILE_INDEX   = 0,
  parameter int unsigned PHASE_CYCLES = bsl_pkg::RESET_PHASE_CYCLES,
  parameter int unsigned GPIO_COUNT   = 8
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  boot_strap_bit0,
  input  wire logic                  boot_strap_bit1,
  input  wire logic                  boot_strap_bit2,
  input  wire logic [31:0]           security_word,
  input  wire logic [7:0]            src_byte,
  input  wire logic                  src_valid,
  output logic                       src_ready,
  output logic [31:0]                otp_addr,
  output logic [31:0]                ram_addr,
  output logic [31:0]                ram_wdata,
  output logic                       ram_we,
  input  wire logic                  ram_ready,
  output logic [GPIO_COUNT-1:0]      gpio_pull_down,
  output logic [2:0]                 boot_source,
  output logic                       first_interchip_link,
  output logic                       link_two_wire,
  output logic                       boot_busy,
  output logic                       run_start,
  output logic [31:0]                run_addr,
  output logic                       boot_fail
);

  // Elaboration checks on parameters the logic cannot serve
  // Straps need two sync edges before the phase end reads them
  if (PHASE_CYCLES < 3) begin : g_chk_phase
    $error("PHASE_CYCLES must be at least three");
  end
  if (TILE_INDEX > 1) begin : g_chk_tile
    $error("TILE_INDEX must be 0 or 1");
  end
  if (GPIO_COUNT < 1) begin : g_chk_gpio
    $error("GPIO_COUNT must be at least one");
  end

  // One reflected CRC-32 byte step, used for count and program bytes
  function automatic logic [31:0] crc_byte(input logic [31:0] crc,
                                           input logic [7:0]  data);
    logic [31:0] c;
    c = crc ^ {24'h00_0000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ bsl_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Two-flop synchronisers for the strap pins
  logic [2:0] strap_meta_ff;    // First stage, read by second only
  logic [2:0] strap_sync_ff;    // Safe strap levels

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_ff <= 3'h0;
      strap_sync_ff <= 3'h0;
    end else begin
      strap_meta_ff <= {boot_strap_bit2, boot_strap_bit1, boot_strap_bit0};
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // Control and datapath registers
  bsl_pkg::bsl_state_e state_ff;   // Loader phase
  logic [31:0] phase_cnt_ff;       // Internal reset phase counter
  logic [1:0]  byte_idx_ff;        // Byte position inside a word
  logic [31:0] shift_ff;           // Little-endian word assembly
  logic [31:0] words_left_ff;      // Program words still to come
  logic [31:0] crc_ff;             // Running CRC register
  logic [31:0] wr_addr_ff;         // Next RAM word address

  // Two-entry buffer between the assembler and RAM writes
  logic [31:0] buf_data_ff [2];    // Storage by index
  logic [31:0] buf_addr_ff [2];
  logic        buf_wp_ff;          // Write index
  logic        buf_rp_ff;          // Read index
  logic [1:0]  buf_cnt_ff;         // Occupancy

  // Output registers
  logic [2:0]  boot_source_ff;
  logic        link_en_ff;
  logic        src_ready_ff;
  logic        ram_we_ff;
  logic [31:0] ram_addr_ff;
  logic [31:0] ram_wdata_ff;
  logic        run_start_ff;
  logic        boot_fail_ff;
  logic        boot_busy_ff;       // Loading under way
  logic        gpio_pd_ff;
  logic [31:0] otp_addr_ff;

  // Boot source decode, secure boot taking precedence
  wire logic       secure_boot = security_word[bsl_pkg::SECURE_BOOT_BIT];
  wire logic [2:0] tile0_src =
    (strap_sync_ff == bsl_pkg::STRAP_QSPI_HOST) ? bsl_pkg::SRC_QSPI_HOST :
    (strap_sync_ff == bsl_pkg::STRAP_SPI_HOST)  ? bsl_pkg::SRC_SPI_HOST :
    (strap_sync_ff == bsl_pkg::STRAP_SPI_TGT_A ||
     strap_sync_ff == bsl_pkg::STRAP_SPI_TGT_B) ? bsl_pkg::SRC_SPI_TGT :
    (strap_sync_ff == bsl_pkg::STRAP_CHAN_END)  ? bsl_pkg::SRC_CHAN_END :
                                                  bsl_pkg::SRC_NONE;
  wire logic [2:0] tile1_src =
    (strap_sync_ff == bsl_pkg::STRAP_SPI_TGT_B) ? bsl_pkg::SRC_SPI_TGT :
    (strap_sync_ff <= bsl_pkg::STRAP_CHAN_END)  ? bsl_pkg::SRC_CHAN_END :
                                                  bsl_pkg::SRC_NONE;
  wire logic [2:0] pick_src = secure_boot ? bsl_pkg::SRC_OTP :
                              (TILE_INDEX == 0) ? tile0_src : tile1_src;
  wire logic       pick_link = !secure_boot &&
                               (strap_sync_ff == bsl_pkg::STRAP_CHAN_END);

  // Byte handshake and word assembly, LSB first
  wire logic        byte_take  = src_ready_ff && src_valid;
  wire logic [31:0] word_now   = {src_byte, shift_ff[31:8]};
  wire logic        word_done  = byte_take && (byte_idx_ff == 2'h3);
  wire logic [31:0] crc_next   = crc_byte(crc_ff, src_byte);
  wire logic        buf_full   = (buf_cnt_ff == 2'h2);
  wire logic        buf_empty  = (buf_cnt_ff == 2'h0);
  wire logic        buf_push   = word_done && (state_ff == bsl_pkg::BSL_BODY);
  wire logic        buf_pop    = !buf_empty && (!ram_we_ff || ram_ready);
  wire logic        in_load    = (state_ff == bsl_pkg::BSL_SIZE) ||
                                 (state_ff == bsl_pkg::BSL_BODY) ||
                                 (state_ff == bsl_pkg::BSL_CHECK);
  // Stall the source when buffer could overflow on this byte
  // Also drop ready on the last check byte, so nothing is taken after end
  wire logic        nxt_src_ready = in_load && !buf_full &&
                                    !(buf_cnt_ff == 2'h1 && !buf_pop &&
                                      byte_idx_ff == 2'h3 && byte_take) &&
                                    !(state_ff == bsl_pkg::BSL_CHECK &&
                                      word_done);
  wire logic        check_pass =
    (word_now == bsl_pkg::CRC_SKIP_VALUE) ||
    (word_now == ~crc_ff);

  // Next state of the loader
  bsl_pkg::bsl_state_e nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bsl_pkg::BSL_RESET_PHASE: begin
        if (phase_cnt_ff >= PHASE_CYCLES - 1) begin
          nxt_state = (pick_src == bsl_pkg::SRC_NONE) ?
                      bsl_pkg::BSL_FAIL : bsl_pkg::BSL_SIZE;
        end
      end
      bsl_pkg::BSL_SIZE: begin
        if (word_done) begin
          nxt_state = (word_now == 32'h0000_0000) ?
                      bsl_pkg::BSL_CHECK : bsl_pkg::BSL_BODY;
        end
      end
      bsl_pkg::BSL_BODY: begin
        if (word_done && words_left_ff == 32'h0000_0001) begin
          nxt_state = bsl_pkg::BSL_CHECK;
        end
      end
      bsl_pkg::BSL_CHECK: begin
        // Verdict on the last check byte; the RAM drain is awaited later by run start
        if (word_done) begin
          nxt_state = check_pass ? bsl_pkg::BSL_RUN :
                                   bsl_pkg::BSL_FAIL;
        end
      end
      bsl_pkg::BSL_RUN:  nxt_state = bsl_pkg::BSL_RUN;
      bsl_pkg::BSL_FAIL: nxt_state = bsl_pkg::BSL_FAIL;
      default:           nxt_state = bsl_pkg::BSL_FAIL;
    endcase
  end

  // Start of execution waits for RAM writes to drain
  wire logic ram_idle  = buf_empty && (!ram_we_ff || ram_ready);
  wire logic nxt_start = (state_ff == bsl_pkg::BSL_RUN) && ram_idle &&
                         !run_start_ff;

  // Phase counter, straps latched once at its end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff       <= bsl_pkg::BSL_RESET_PHASE;
      phase_cnt_ff   <= 32'h0000_0000;
      boot_source_ff <= bsl_pkg::SRC_NONE;
      link_en_ff     <= 1'b0;
      gpio_pd_ff     <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == bsl_pkg::BSL_RESET_PHASE) begin
        phase_cnt_ff <= phase_cnt_ff + 32'h0000_0001;
        if (nxt_state != bsl_pkg::BSL_RESET_PHASE) begin
          boot_source_ff <= pick_src;
          link_en_ff     <= pick_link;
          gpio_pd_ff     <= 1'b0;
        end
      end
    end
  end

  // Byte assembly, word count and CRC
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_idx_ff   <= 2'h0;
      shift_ff      <= 32'h0000_0000;
      words_left_ff <= 32'h0000_0000;
      crc_ff        <= bsl_pkg::CRC_PRESET;
      src_ready_ff  <= 1'b0;
    end else begin
      src_ready_ff <= nxt_src_ready;
      if (byte_take) begin
        byte_idx_ff <= byte_idx_ff + 2'h1;
        shift_ff    <= word_now;
        // Check word bytes stay out of the CRC
        if (state_ff != bsl_pkg::BSL_CHECK) begin
          crc_ff <= crc_next;
        end
      end
      if (word_done && state_ff == bsl_pkg::BSL_SIZE) begin
        words_left_ff <= word_now;
      end else if (buf_push) begin
        words_left_ff <= words_left_ff - 32'h0000_0001;
      end
    end
  end

  // Two-entry buffer, then RAM write port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_data_ff[0] <= 32'h0000_0000;
      buf_data_ff[1] <= 32'h0000_0000;
      buf_addr_ff[0] <= 32'h0000_0000;
      buf_addr_ff[1] <= 32'h0000_0000;
      buf_wp_ff      <= 1'b0;
      buf_rp_ff      <= 1'b0;
      buf_cnt_ff     <= 2'h0;
      wr_addr_ff     <= bsl_pkg::RAM_BASE;
      ram_we_ff      <= 1'b0;
      ram_addr_ff    <= 32'h0000_0000;
      ram_wdata_ff   <= 32'h0000_0000;
    end else begin
      if (buf_push) begin
        buf_data_ff[buf_wp_ff] <= word_now;
        buf_addr_ff[buf_wp_ff] <= wr_addr_ff;
        buf_wp_ff              <= ~buf_wp_ff;
        wr_addr_ff             <= wr_addr_ff + 32'h0000_0004;
      end
      buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
      if (buf_pop) begin
        ram_we_ff    <= 1'b1;
        ram_addr_ff  <= buf_addr_ff[buf_rp_ff];
        ram_wdata_ff <= buf_data_ff[buf_rp_ff];
        buf_rp_ff    <= ~buf_rp_ff;
      end else if (ram_ready) begin
        ram_we_ff <= 1'b0;
      end
    end
  end

  // Outcome flags and OTP read pointer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_start_ff <= 1'b0;
      boot_fail_ff <= 1'b0;
      boot_busy_ff <= 1'b0;
      otp_addr_ff  <= bsl_pkg::OTP_BASE;
    end else begin
      run_start_ff <= run_start_ff | nxt_start;
      boot_fail_ff <= (nxt_state == bsl_pkg::BSL_FAIL);
      // Busy from phase end until the program starts or boot fails
      boot_busy_ff <= (nxt_state != bsl_pkg::BSL_RESET_PHASE) &&
                      (nxt_state != bsl_pkg::BSL_FAIL) &&
                      !(run_start_ff || nxt_start);
      // OTP byte pointer advances per accepted byte from address 0
      if (boot_source_ff == bsl_pkg::SRC_OTP && byte_take) begin
        otp_addr_ff <= otp_addr_ff + 32'h0000_0001;
      end
    end
  end

  // Outputs straight from flip-flops, except run_addr which is the constant RAM_BASE
  assign src_ready            = src_ready_ff;
  assign otp_addr             = otp_addr_ff;
  assign ram_addr             = ram_addr_ff;
  assign ram_wdata            = ram_wdata_ff;
  assign ram_we               = ram_we_ff;
  assign gpio_pull_down       = {GPIO_COUNT{gpio_pd_ff}};
  assign boot_source          = boot_source_ff;
  assign first_interchip_link = link_en_ff;
  assign link_two_wire        = link_en_ff;
  assign boot_busy            = boot_busy_ff;
  assign run_start            = run_start_ff;
  assign run_addr             = bsl_pkg::RAM_BASE;
  assign boot_fail            = boot_fail_ff;

endmodule

`default_nettype wire

//--- logic/bsl_pkg.sv
// Shared constants and types for the boot source and image loader
package bsl_pkg;

  // Internal reset phase: least time 15 us at the 20 MHz core clock
  localparam int unsigned CLK_HZ             = 20_000_000;
  localparam int unsigned RESET_PHASE_US     = 15;
  localparam int unsigned RESET_PHASE_CYCLES =
    (RESET_PHASE_US * (CLK_HZ / 1_000_000));

  // Image check constants
  localparam logic [31:0] CRC_SKIP_VALUE = 32'h0D15_AB1E;
  localparam logic [31:0] CRC_POLY       = 32'hEDB8_8320;
  localparam logic [31:0] CRC_PRESET     = 32'hFFFF_FFFF;

  // Bit position of secure boot in the security word
  localparam int unsigned SECURE_BOOT_BIT = 5;

  // First RAM and OTP address
  localparam logic [31:0] RAM_BASE = 32'h0000_0000;
  localparam logic [31:0] OTP_BASE = 32'h0000_0000;

  // Strap codes {bit2,bit1,bit0}
  localparam logic [2:0] STRAP_QSPI_HOST = 3'h0;
  localparam logic [2:0] STRAP_SPI_HOST  = 3'h1;
  localparam logic [2:0] STRAP_SPI_TGT_A = 3'h2;
  localparam logic [2:0] STRAP_SPI_TGT_B = 3'h3;
  localparam logic [2:0] STRAP_CHAN_END  = 3'h4;

  // Boot source codes shown on boot_source
  localparam logic [2:0] SRC_NONE      = 3'h0;
  localparam logic [2:0] SRC_QSPI_HOST = 3'h1;
  localparam logic [2:0] SRC_SPI_HOST  = 3'h2;
  localparam logic [2:0] SRC_SPI_TGT   = 3'h3;
  localparam logic [2:0] SRC_CHAN_END  = 3'h4;
  localparam logic [2:0] SRC_OTP       = 3'h5;

  // Loader states
  typedef enum logic [2:0] {
    BSL_RESET_PHASE,
    BSL_SIZE,
    BSL_BODY,
    BSL_CHECK,
    BSL_RUN,
    BSL_FAIL
  } bsl_state_e;

endpackage
